// ===== design/pief_top.sv
// peripheral interrupt enable and flag registers with a classic wishbone slave
//
// Contract
// - enable bit 6 gates the converter completion flag onto the peripheral request.
// - enable bit 5 gates the serial receive buffer full flag onto the request.
// - a source requests only while its enable is 1, and its flag still sets while it is 0.
// - enable bits are ordered parallel 7, converter 6, rx 5, tx 4, sync 3, capcomp 2, t2 1, t1 0.
// - a flag sets on its event regardless of its enable and of the global enable.
// - the flag register uses the same bit positions as the enable register.
// - no source of the group raises CORE_PERIPH_REQ or CORE_IRQ_REQ unless the group enable in core control is set; IRQ ignores the group enable.

`timescale 1ns/1ps
`default_nettype none
`include "pief_defines.svh"

module pief_top
   import pief_pkg::*;
#(
   parameter bit HAS_PARALLEL_PORT = 1'b1
)
(
   input  wire logic        CORE_CLK,
   input  wire logic        RST_N,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   input  wire logic [7:0]  PERIPH_EVT,
   input  wire logic        SERIAL_RX_FULL,
   input  wire logic        SERIAL_TX_EMPTY,
   output logic             CORE_PERIPH_REQ,
   output logic             CORE_IRQ_REQ,
   output logic             IRQ
);

   localparam logic [7:0] SRC_MASK = HAS_PARALLEL_PORT ? `PIEF_ALL_MASK : `PIEF_NO_PARALLEL_MASK;
   localparam logic [7:0] EVT_MASK = SRC_MASK & ~`PIEF_FLAGS_RO_MASK;

   pief_bus_state_t             state_ff;
   pief_bus_state_t             nxt_state;
   logic            [31:0]      rdat_ff;
   logic            [7:0]       rdat_mux;
   pief_src_t                   en_ff;
   pief_src_t                   flags_ff;
   pief_src_t                   nxt_flags;
   logic            [1:0]       core_ctrl_ff;
   logic            [`PIEF_STAT_W-1:0] status_ff;
   logic            [`PIEF_STAT_W-1:0] nxt_status;
   logic            [`PIEF_STAT_W-1:0] status_set;
   logic            [`PIEF_STAT_W-1:0] mask_ff;
   logic                        periph_any_ff;
   logic                        periph_req_ff;
   logic                        core_req_ff;
   logic            [7:0]       word_adr;
   logic                        req_new;
   logic                        wr_commit;
   logic                        hit_ctrl;
   logic                        hit_en;
   logic                        hit_flags;
   logic                        hit_status;
   logic                        hit_mask;
   logic            [7:0]       evt_eff;
   logic            [7:0]       flag_wr_val;
   logic            [7:0]       gated;
   logic                        periph_any;
   logic                        group_en;
   logic                        global_en;

   // bus decode; the byte offset bits are ignored, each register is one aligned word
   assign word_adr   = {WB_ADR_I[7:2], 2'b00};
   assign hit_ctrl   = (word_adr == `PIEF_ADR_CORE_CTRL);
   assign hit_en     = (word_adr == `PIEF_ADR_PERIPH_EN);
   assign hit_flags  = (word_adr == `PIEF_ADR_PERIPH_FLAGS);
   assign hit_status = (word_adr == `PIEF_ADR_IRQ_STATUS);
   assign hit_mask   = (word_adr == `PIEF_ADR_IRQ_MASK);
   assign req_new    = WB_CYC_I & WB_STB_I & (state_ff == PIEF_ST_IDLE);
   // writes land on the edge where the master sees ack, so a held request commits once
   assign wr_commit  = WB_CYC_I & WB_STB_I & WB_WE_I & WB_SEL_I[0] & (state_ff == PIEF_ST_ACK);

   always_comb
   begin
      nxt_state = PIEF_ST_IDLE;
      case (state_ff)
         PIEF_ST_IDLE:
         begin
            if (req_new)
            begin
               nxt_state = PIEF_ST_ACK;
            end
         end
         PIEF_ST_ACK:
         begin
            nxt_state = PIEF_ST_IDLE;
         end
         default:
         begin
            nxt_state = PIEF_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state_ff <= PIEF_ST_IDLE;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign WB_ACK_O = (state_ff == PIEF_ST_ACK);

   // unmapped words read as zero and ignore writes
   always_comb
   begin
      rdat_mux = 8'h00;
      if (hit_ctrl)
      begin
         rdat_mux[`PIEF_BIT_GLOBAL_EN] = core_ctrl_ff[1];
         rdat_mux[`PIEF_BIT_GROUP_EN]  = core_ctrl_ff[0];
      end
      else if (hit_en)
      begin
         rdat_mux = en_ff;
      end
      else if (hit_flags)
      begin
         rdat_mux = flags_ff;
      end
      else if (hit_status)
      begin
         rdat_mux = {6'h00, status_ff};
      end
      else if (hit_mask)
      begin
         rdat_mux = {6'h00, mask_ff};
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rdat_ff <= 32'h0000_0000;
      end
      else if (req_new)
      begin
         rdat_ff <= {24'h00_0000, rdat_mux};
      end
   end

   assign WB_DAT_O = rdat_ff;

   // enable register; bit 7 is not stored on parts without the parallel port
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         en_ff <= `PIEF_RST_PERIPH_EN;
      end
      else if (wr_commit && hit_en)
      begin
         en_ff <= WB_DAT_I[7:0] & SRC_MASK;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         core_ctrl_ff <= `PIEF_RST_CORE_CTRL;
      end
      else if (wr_commit && hit_ctrl)
      begin
         core_ctrl_ff <= {WB_DAT_I[`PIEF_BIT_GLOBAL_EN], WB_DAT_I[`PIEF_BIT_GROUP_EN]};
      end
   end

   assign global_en = core_ctrl_ff[1];
   assign group_en  = core_ctrl_ff[0];

   // flags: an event wins over a software clear in the same cycle
   assign evt_eff     = PERIPH_EVT & EVT_MASK;
   assign flag_wr_val = (wr_commit && hit_flags) ? WB_DAT_I[7:0] : flags_ff;

   always_comb
   begin
      nxt_flags           = (flag_wr_val | evt_eff) & EVT_MASK;
      // rx and tx flags mirror the buffer state, software cannot touch them
      nxt_flags.serial_rx = SERIAL_RX_FULL;
      nxt_flags.serial_tx = SERIAL_TX_EMPTY;
   end

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         flags_ff <= `PIEF_RST_PERIPH_FLAGS;
      end
      else
      begin
         flags_ff <= nxt_flags;
      end
   end

   // per-source gating shares one bit order for flags and enables
   assign gated      = flags_ff & en_ff;
   assign periph_any = |gated;

   // registered request lines, one cycle behind the flag and enable state
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         periph_any_ff <= 1'b0;
         periph_req_ff <= 1'b0;
         core_req_ff   <= 1'b0;
      end
      else
      begin
         periph_any_ff <= periph_any;
         periph_req_ff <= periph_any & group_en;
         core_req_ff   <= periph_any & group_en & global_en;
      end
   end

   assign CORE_PERIPH_REQ = periph_req_ff;
   assign CORE_IRQ_REQ    = core_req_ff;

   // sticky status: periph_any rising and event on an already pending flag
   always_comb
   begin
      status_set                      = '0;
      status_set[`PIEF_STAT_REQ_RISE] = periph_any & ~periph_any_ff;
      status_set[`PIEF_STAT_OVERRUN]  = |(evt_eff & flags_ff);
      nxt_status                      = status_ff;
      if (wr_commit && hit_status)
      begin
         nxt_status = status_ff & ~WB_DAT_I[`PIEF_STAT_W-1:0];
      end
      nxt_status = nxt_status | status_set;
   end

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         status_ff <= `PIEF_RST_STATUS;
      end
      else
      begin
         status_ff <= nxt_status;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         mask_ff <= `PIEF_RST_MASK;
      end
      else if (wr_commit && hit_mask)
      begin
         mask_ff <= WB_DAT_I[`PIEF_STAT_W-1:0];
      end
   end

   assign IRQ = |(status_ff & mask_ff);

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_N);

   conv_gate_a: assert property (
      (flags_ff.converter && en_ff.converter && group_en) |=> CORE_PERIPH_REQ)
      else $error("converter flag with enable gave no request");

   rx_gate_a: assert property (
      (SERIAL_RX_FULL && en_ff.serial_rx && group_en) ##1 (en_ff.serial_rx && group_en)
      |=> CORE_PERIPH_REQ)
      else $error("rx full with enable gave no request");

   no_enable_a: assert property (
      (en_ff == 8'h00) |=> !CORE_PERIPH_REQ)
      else $error("request raised with all enables clear");

   en_write_a: assert property (
      (wr_commit && hit_en) |=> (en_ff == ($past(WB_DAT_I[7:0]) & SRC_MASK)))
      else $error("enable register did not take written value");

   flag_set_a: assert property (
      PERIPH_EVT[`PIEF_BIT_TIMER_ONE] |=> flags_ff.timer_one_ovf)
      else $error("timer one event did not set its flag");

   evt_vs_clear_a: assert property (
      (PERIPH_EVT[`PIEF_BIT_CONVERTER] && wr_commit && hit_flags && !WB_DAT_I[6])
      |=> flags_ff.converter)
      else $error("software clear beat a converter event");

   ro_flags_a: assert property (
      ##1 (flags_ff.serial_rx == $past(SERIAL_RX_FULL))
      && (flags_ff.serial_tx == $past(SERIAL_TX_EMPTY)))
      else $error("rx or tx flag does not follow its buffer");

   group_gate_a: assert property (
      !group_en |=> !CORE_PERIPH_REQ && !CORE_IRQ_REQ)
      else $error("request raised with group enable clear");

   any_req_a: assert property (
      (periph_any && group_en) |=> CORE_PERIPH_REQ)
      else $error("gated flag did not raise request");

   ack_pulse_a: assert property (
      WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held more than one cycle");

   ack_req_a: assert property (
      req_new |=> WB_ACK_O)
      else $error("bus request not answered next cycle");

   irq_level_a: assert property (
      (status_ff[`PIEF_STAT_REQ_RISE] && mask_ff[`PIEF_STAT_REQ_RISE]) |-> IRQ)
      else $error("unmasked status bit without irq");

   // a sticky bit may only drop through a status write
   status_hold_a: assert property (
      (status_ff[`PIEF_STAT_OVERRUN] && !(wr_commit && hit_status))
      |=> status_ff[`PIEF_STAT_OVERRUN])
      else $error("overrun status bit lost without a clear");

   core_req_c: cover property (
      !CORE_IRQ_REQ ##1 CORE_IRQ_REQ);

   flag_clear_c: cover property (
      flags_ff.capcomp_unit && wr_commit && hit_flags ##1 !flags_ff.capcomp_unit);

   overrun_c: cover property (
      status_set[`PIEF_STAT_OVERRUN] && mask_ff[`PIEF_STAT_OVERRUN] ##1 IRQ);

   disabled_flag_c: cover property (
      flags_ff.sync_serial && !en_ff.sync_serial);

endmodule // pief_top

`default_nettype wire

// ===== design/pief_defines.svh
// register offsets, field positions and reset values of the peripheral interrupt block
`ifndef PIEF_DEFINES_SVH
`define PIEF_DEFINES_SVH

`define PIEF_ADR_CORE_CTRL     8'h88
`define PIEF_ADR_PERIPH_EN     8'h8c
`define PIEF_ADR_PERIPH_FLAGS  8'h90
`define PIEF_ADR_IRQ_STATUS    8'h94
`define PIEF_ADR_IRQ_MASK      8'h98

`define PIEF_BIT_PARALLEL      7
`define PIEF_BIT_CONVERTER     6
`define PIEF_BIT_SERIAL_RX     5
`define PIEF_BIT_SERIAL_TX     4
`define PIEF_BIT_SYNC_SERIAL   3
`define PIEF_BIT_CAPCOMP       2
`define PIEF_BIT_TIMER_TWO     1
`define PIEF_BIT_TIMER_ONE     0

`define PIEF_BIT_GLOBAL_EN     7
`define PIEF_BIT_GROUP_EN      6

`define PIEF_STAT_REQ_RISE     0
`define PIEF_STAT_OVERRUN      1
`define PIEF_STAT_W            2

`define PIEF_RST_PERIPH_EN     8'h00
`define PIEF_RST_PERIPH_FLAGS  8'h00
`define PIEF_RST_CORE_CTRL     2'h0
`define PIEF_RST_STATUS        2'h0
`define PIEF_RST_MASK          2'h0

`define PIEF_FLAGS_RO_MASK     8'h30
`define PIEF_NO_PARALLEL_MASK  8'h7f
`define PIEF_ALL_MASK          8'hff

`endif

// ===== design/pief_pkg.sv
// types shared by the peripheral interrupt block
package pief_pkg;

   typedef struct packed {
      logic parallel_port;
      logic converter;
      logic serial_rx;
      logic serial_tx;
      logic sync_serial;
      logic capcomp_unit;
      logic timer_two_match;
      logic timer_one_ovf;
   } pief_src_t;

   typedef enum logic [1:0] {
      PIEF_ST_IDLE = 2'b01,
      PIEF_ST_ACK  = 2'b10
   } pief_bus_state_t;

endpackage

// ===== verif/pief_periph_model.sv
// far-side model: peripheral event sources and serial buffer levels
`timescale 1ns/1ps
`default_nettype none
module pief_periph_model
(
   input  wire logic       clk,
   output logic      [7:0] evt,
   output logic            rx_full,
   output logic            tx_empty
);
   initial
   begin
      evt      = 8'h00;
      rx_full  = 1'b0;
      tx_empty = 1'b0;
   end
   // single-cycle pulse; a held level would set the flag on every cycle
   task automatic pulse(input int idx);
      @(posedge clk);
      evt[idx] <= 1'b1;
      @(posedge clk);
      evt <= 8'h00;
   endtask
   // buffer levels, not events; the flags follow them one cycle later
   task automatic set_buf(input logic rx, input logic tx);
      @(posedge clk);
      rx_full  <= rx;
      tx_empty <= tx;
   endtask
endmodule // pief_periph_model
`default_nettype wire

// ===== verif/tb_peripheral_interrupt_enable_flags.sv
// self-checking bench for the peripheral interrupt enable and flag block
`timescale 1ns/1ps
`default_nettype none
module tb_peripheral_interrupt_enable_flags
   import pief_pkg::*;
;
   logic        core_clk;
   logic        rst_n;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [31:0] wdat;
   logic [3:0]  sel;
   logic [31:0] dat_o;
   logic [31:0] rdat;
   logic        ack;
   logic [7:0]  evt;
   logic        rx_full;
   logic        tx_empty;
   logic        preq;
   logic        creq;
   logic        irq;
   int          n_fail;
   int          checks_done;
   int          cycles;

   pief_top uut (
      .CORE_CLK(core_clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
      .WB_DAT_O(dat_o), .WB_ACK_O(ack), .PERIPH_EVT(evt),
      .SERIAL_RX_FULL(rx_full), .SERIAL_TX_EMPTY(tx_empty),
      .CORE_PERIPH_REQ(preq), .CORE_IRQ_REQ(creq), .IRQ(irq)
   );
   pief_periph_model model (
      .clk(core_clk), .evt(evt), .rx_full(rx_full), .tx_empty(tx_empty)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic print_verdict();
      if (n_fail == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // a hung bus or a stuck test ends here rather than running forever
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         n_fail++;
         print_verdict();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= {24'h000000, d};
      // only the bench timeout ends a wait for ack
      do
      begin
         @(posedge core_clk);
      end while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, d);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(rdat, {24'h000000, e});
   endtask

   // requests are registered, so allow two edges before looking
   task automatic req_chk(input logic p, input logic c);
      repeat (2) @(posedge core_clk);
      #1;
      chk({30'h0, preq, creq}, {30'h0, p, c});
   endtask

   initial
   begin
      logic [7:0] m;
      logic [7:0] regs [6];
      regs = '{8'h88, 8'h8c, 8'h90, 8'h94, 8'h98, 8'ha0};
      rst_n = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      wdat = 32'h00000000;
      sel = 4'h1;
      n_fail = 0;
      checks_done = 0;
      cycles = 0;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 6; i++)
         rd_chk(regs[i], 8'h00);
      // this part has the parallel port, so bit 7 may be written as one
      wr(8'h8c, 8'hff);
      rd_chk(8'h8c, 8'hff);
      wr(8'h8c, 8'h00);
      model.pulse(6);
      rd_chk(8'h90, 8'h40);
      wr(8'h88, 8'hc0);
      req_chk(1'b0, 1'b0);
      for (int i = 0; i < 8; i++)
         if (i != 5 && i != 4)
         begin
            m = 8'h01 << i;
            wr(8'h90, 8'h00);
            wr(8'h8c, m);
            model.pulse(i);
            rd_chk(8'h90, m);
            req_chk(1'b1, 1'b1);
         end
      wr(8'h88, 8'h80);
      req_chk(1'b0, 1'b0);
      wr(8'h88, 8'h40);
      req_chk(1'b1, 1'b0);
      wr(8'h90, 8'h00);
      wr(8'h8c, 8'h20);
      model.set_buf(1'b1, 1'b0);
      rd_chk(8'h90, 8'h20);
      wr(8'h90, 8'h00);
      rd_chk(8'h90, 8'h20);
      req_chk(1'b1, 1'b0);
      model.set_buf(1'b0, 1'b1);
      rd_chk(8'h90, 8'h10);
      rd_chk(8'h94, 8'h01);
      chk({31'h0, irq}, 32'h0);
      wr(8'h98, 8'h01);
      #1;
      chk({31'h0, irq}, 32'h1);
      wr(8'h94, 8'h03);
      #1;
      chk({31'h0, irq}, 32'h0);
      rd_chk(8'h94, 8'h00);
      wr(8'h98, 8'h02);
      model.pulse(0);
      model.pulse(0);
      rd_chk(8'h94, 8'h02);
      #1;
      chk({31'h0, irq}, 32'h1);
      // converter event lands in the ack cycle of a clearing write
      fork
         wr(8'h90, 8'h00);
         begin
            @(posedge core_clk);
            model.pulse(6);
         end
      join
      rd_chk(8'h90, 8'h50);
      // a write without the low byte select is acked but dropped
      sel <= 4'h0;
      wr(8'h8c, 8'hff);
      sel <= 4'h1;
      rd_chk(8'h8c, 8'h20);
      wr(8'ha0, 8'hff);
      rd_chk(8'ha0, 8'h00);
      print_verdict();
   end
endmodule // tb_peripheral_interrupt_enable_flags
`default_nettype wire
